// ===== xps_map.vh
`ifndef XPS_MAP_VH
`define XPS_MAP_VH

// ==========================================================
// Register offsets (8-bit command byte)
`define XPS_OFS_ROUTE      8'h00
`define XPS_OFS_CTRL       8'h03
`define XPS_OFS_PRESENCE   8'h04

// ==========================================================
// Control register fields
`define XPS_CTRL_KEEP_LSB  0
`define XPS_CTRL_KEEP_MSB  3
`define XPS_CTRL_IGN_EQ    4
`define XPS_CTRL_IGN_PE    5
`define XPS_CTRL_FORCE     6
`define XPS_CTRL_SOFT      7

// ==========================================================
// Reset values
`define XPS_RST_ROUTE      8'h00
`define XPS_RST_CTRL       8'h0F
`define XPS_RST_PRESENCE   4'h0

// ==========================================================
// Target address (arbitrary value)
`define XPS_SMB_ADDR       7'h5A

`endif

// ===== xps_power_status.v
// Functional notes
// - Control bit 7 soft sleep, resets 0; writing 0 requests power-down.
// - Device runs when sleep pin OR soft bit is high; sleeps when both low.
// - In power-down only the serial target stays alive; loss detect stays on only with force-on.
// - In power-down, force-on bit powers all receivers and loss detectors.
// - Powered up, idle logic turns off every port the routing leaves unused, unless force-on is set.
// - Output enabled only if routing needs it and its keep-alive bit is one.
// - Input enabled if a live output's routing selects it or the force-on bit is one.
// - Presence bits 0..3, one per input, 1 = valid signal, read-only, reset 0.
// - Presence bits 7..4 are reserved and read-only.
// - Control bits 3..0 are output keep-alives, reset 1111; 0 powers output off.
// - Control bit 6 keeps all inputs and loss detectors powered regardless of routing.
// - Routing holds a 2-bit input select per output, defining which ports are used.
`timescale 1ns/1ps
`default_nettype none
`include "xps_map.vh"

module xps_power_status (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe_n,
    input  wire       chip_sleep_pin_n,
    input  wire [3:0] signal_present_raw,
    output wire       core_powered,
    output wire [3:0] rx_enable,
    output wire [3:0] loss_detect_enable,
    output wire [3:0] tx_enable,
    output wire [7:0] route_sel
);

    // ==========================================================
    // Target states
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_ADDR  = 4'h1;
    localparam [3:0] ST_AACK  = 4'h2;
    localparam [3:0] ST_CMD   = 4'h3;
    localparam [3:0] ST_CACK  = 4'h4;
    localparam [3:0] ST_WDAT  = 4'h5;
    localparam [3:0] ST_WACK  = 4'h6;
    localparam [3:0] ST_RDAT  = 4'h7;
    localparam [3:0] ST_RACK  = 4'h8;

    // ==========================================================
    // Input synchronisers
    reg  [1:0] scl_s_r;
    reg  [1:0] sda_s_r;
    reg        scl_d_r;
    reg        sda_d_r;
    reg  [1:0] pin_s_r;
    reg  [3:0] pres_s1_r;
    reg  [3:0] pres_s2_r;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s_r   <= 2'h3;
            sda_s_r   <= 2'h3;
            scl_d_r   <= 1'b1;
            sda_d_r   <= 1'b1;
            pin_s_r   <= 2'h0;
            pres_s1_r <= 4'h0;
            pres_s2_r <= 4'h0;
        end else begin
            scl_s_r   <= {scl_s_r[0], scl_in};
            sda_s_r   <= {sda_s_r[0], sda_in};
            scl_d_r   <= scl_s_r[1];
            sda_d_r   <= sda_s_r[1];
            pin_s_r   <= {pin_s_r[0], chip_sleep_pin_n};
            pres_s1_r <= signal_present_raw;
            pres_s2_r <= pres_s1_r;
        end
    end

    wire scl_c    = scl_s_r[1];
    wire sda_c    = sda_s_r[1];
    wire scl_rise = scl_c & ~scl_d_r;
    wire scl_fall = ~scl_c & scl_d_r;
    wire bus_start = scl_c & scl_d_r & sda_d_r & ~sda_c;
    wire bus_stop  = scl_c & scl_d_r & ~sda_d_r & sda_c;

    // ==========================================================
    // Registers and power decode
    reg  [7:0] route_r;
    reg  [7:0] ctrl_r;
    reg  [3:0] used_in;
    integer    k;

    wire       soft_sleep_bit_n      = ctrl_r[`XPS_CTRL_SOFT];
    wire       loss_detect_force_on  = ctrl_r[`XPS_CTRL_FORCE];
    wire [3:0] output_keepalive_bits = ctrl_r[`XPS_CTRL_KEEP_MSB:`XPS_CTRL_KEEP_LSB];

    // Sleep only when both are low
    assign core_powered = pin_s_r[1] | soft_sleep_bit_n;

    // Every output always has a source, so each is needed by the routing
    assign tx_enable = core_powered ? output_keepalive_bits : 4'h0;

    // An input counts as used when any live output selects it
    always @* begin
        used_in = 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            if (output_keepalive_bits[k]) begin
                used_in[route_r[2*k +: 2]] = 1'b1;
            end
        end
    end

    // auto_idle_logic: unused inputs sleep unless forced on
    assign rx_enable = core_powered ? (used_in | {4{loss_detect_force_on}})
                                    : {4{loss_detect_force_on}};
    assign loss_detect_enable = rx_enable;
    assign route_sel          = route_r;

    // Unpowered detectors read as no signal
    wire [7:0] presence = {4'h0, pres_s2_r & loss_detect_enable};

    function [7:0] rd_val;
        input [7:0] ptr;
        begin
            case (ptr)
                `XPS_OFS_ROUTE:    rd_val = route_r;
                `XPS_OFS_CTRL:     rd_val = ctrl_r;
                `XPS_OFS_PRESENCE: rd_val = presence;
                default:           rd_val = 8'h00;
            endcase
        end
    endfunction

    // ==========================================================
    // Serial target: sample on SCL rise, drive after SCL fall
    reg  [3:0] state_r;
    reg  [3:0] bits_r;
    reg  [7:0] sh_r;
    reg  [7:0] ptr_r;
    reg        rd_r;
    reg        nack_r;
    reg        oe_n_r;

    // Addressed register as seen now; bit 7 goes out first
    wire [7:0] rd_now = rd_val(ptr_r);

    assign sda_out  = 1'b0;
    assign sda_oe_n = oe_n_r;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            bits_r  <= 4'h0;
            sh_r    <= 8'h00;
            ptr_r   <= 8'h00;
            rd_r    <= 1'b0;
            nack_r  <= 1'b0;
            oe_n_r  <= 1'b1;
            route_r <= `XPS_RST_ROUTE;
            ctrl_r  <= `XPS_RST_CTRL;
        end else if (bus_start) begin
            state_r <= ST_ADDR;
            bits_r  <= 4'h0;
            oe_n_r  <= 1'b1;
        end else if (bus_stop) begin
            state_r <= ST_IDLE;
            oe_n_r  <= 1'b1;
        end else if (scl_rise) begin
            case (state_r)
                ST_ADDR, ST_CMD, ST_WDAT: begin
                    sh_r   <= {sh_r[6:0], sda_c};
                    bits_r <= bits_r + 4'h1;
                end
                ST_RDAT: begin
                    bits_r <= bits_r + 4'h1;
                end
                ST_RACK: begin
                    nack_r <= sda_c;
                end
                default: begin
                    bits_r <= bits_r;
                end
            endcase
        end else if (scl_fall) begin
            case (state_r)
                ST_ADDR: begin
                    if (bits_r == 4'h8) begin
                        if (sh_r[7:1] == `XPS_SMB_ADDR) begin
                            rd_r    <= sh_r[0];
                            oe_n_r  <= 1'b0;
                            state_r <= ST_AACK;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    bits_r <= 4'h0;
                    if (rd_r) begin
                        sh_r    <= rd_now;
                        oe_n_r  <= rd_now[7];
                        state_r <= ST_RDAT;
                    end else begin
                        oe_n_r  <= 1'b1;
                        state_r <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (bits_r == 4'h8) begin
                        ptr_r   <= sh_r;
                        oe_n_r  <= 1'b0;
                        state_r <= ST_CACK;
                    end
                end
                ST_CACK, ST_WACK: begin
                    bits_r  <= 4'h0;
                    oe_n_r  <= 1'b1;
                    state_r <= ST_WDAT;
                end
                ST_WDAT: begin
                    if (bits_r == 4'h8) begin
                        // Writes take effect on the eighth clock's falling edge, before the stop
                        if (ptr_r == `XPS_OFS_ROUTE) begin
                            route_r <= sh_r;
                        end else if (ptr_r == `XPS_OFS_CTRL) begin
                            ctrl_r <= sh_r;
                        end
                        // Presence and unmapped offsets drop the data
                        ptr_r   <= ptr_r + 8'h01;
                        oe_n_r  <= 1'b0;
                        state_r <= ST_WACK;
                    end
                end
                ST_RDAT: begin
                    if (bits_r == 4'h8) begin
                        oe_n_r  <= 1'b1;
                        state_r <= ST_RACK;
                    end else begin
                        oe_n_r <= sh_r[6];
                        sh_r   <= {sh_r[6:0], 1'b0};
                    end
                end
                ST_RACK: begin
                    bits_r <= 4'h0;
                    if (nack_r) begin
                        oe_n_r  <= 1'b1;
                        state_r <= ST_IDLE;
                    end else begin
                        // Host asked for more: same register again
                        sh_r    <= rd_now;
                        oe_n_r  <= rd_now[7];
                        state_r <= ST_RDAT;
                    end
                end
                default: begin
                    oe_n_r <= 1'b1;
                end
            endcase
        end
    end

endmodule // xps_power_status

`default_nettype wire

// ===== xps_power_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks of the power decode and the data line release
module xps_power_status_monitor (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       chip_sleep_pin_n,
    input wire logic       sda_oe_n,
    input wire logic       core_powered,
    input wire logic [3:0] rx_enable,
    input wire logic [3:0] loss_detect_enable,
    input wire logic [3:0] tx_enable,
    input wire logic [7:0] route_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Inputs feeding live outputs; ctrl is not visible, so live outputs stand in
    logic [3:0] need;
    always_comb begin
        need = 4'h0;
        for (int n = 0; n < 4; n++) begin
            if (tx_enable[n]) need[route_sel[2*n +: 2]] = 1'b1;
        end
    end
    pin_wake_a: assert property (chip_sleep_pin_n [*3] |-> core_powered)
        else $error("pin high but core not powered");
    sleep_tx_a: assert property (!core_powered |-> tx_enable == 4'h0)
        else $error("output enabled in sleep");
    det_rx_a: assert property (loss_detect_enable == rx_enable)
        else $error("detector enable differs from receiver enable");
    need_rx_a: assert property (core_powered |-> (need & ~rx_enable) == 4'h0)
        else $error("routed input not enabled");
    idle_rx_a: assert property (core_powered && rx_enable != 4'hF |-> rx_enable == need)
        else $error("unused input left enabled");
    sleep_rx_a: assert property (!core_powered |-> rx_enable inside {4'h0, 4'hF})
        else $error("partial receiver enable in sleep");
    reset_state_a: assert property ($rose(arst_n) |-> ##1 (!core_powered && route_sel == 8'h00))
        else $error("wrong state after reset");
    ack_bound_a: assert property ($fell(sda_oe_n) |-> ##[1:300] sda_oe_n)
        else $error("data line held low too long");
    cover property ($fell(core_powered));
    cover property (!core_powered && rx_enable == 4'hF);
    cover property (core_powered && tx_enable != 4'hF && tx_enable != 4'h0);
endmodule // xps_power_status_monitor

bind xps_power_status xps_power_status_monitor u_mon (.clk(clk), .arst_n(arst_n),
    .chip_sleep_pin_n(chip_sleep_pin_n), .sda_oe_n(sda_oe_n), .core_powered(core_powered),
    .rx_enable(rx_enable), .loss_detect_enable(loss_detect_enable), .tx_enable(tx_enable),
    .route_sel(route_sel));
`default_nettype wire

// ===== xps_power_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "xps_map.vh"
// ==========================================
// Testbench
module xps_power_status_tb;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       pin_n = 1'b1;
    logic [3:0] raw = 4'h0;
    logic [7:0] q;
    logic [2:0] nak;
    int         err_count = 0;
    int         n_checks = 0;
    wire        scl, sda_h, sda_o, sda_oe_n, pwr;
    wire  [3:0] rx_en, ld_en, tx_en;
    wire  [7:0] route;
    // Pulled-up line: low if either party pulls it
    wire        sda = sda_h & (sda_oe_n | sda_o);
    xps_power_status uut (.clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_n(sda_oe_n), .chip_sleep_pin_n(pin_n),
        .signal_present_raw(raw), .core_powered(pwr), .rx_enable(rx_en),
        .loss_detect_enable(ld_en), .tx_enable(tx_en), .route_sel(route));
    xps_smb_host host (.scl(scl), .sda_drv(sda_h), .sda_line(sda));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Host steps are multiples of the clock period, so starting 1 ns after an edge
    // keeps every pin change off the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 host.wr(a, d, nak);
        chk("ack", {5'h00, nak}, 8'h00);
        repeat (3) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #1 host.rd(a, q);
    endtask
    task automatic pins(input logic p, input logic [3:0] r);
        @(posedge clk);
        #1 pin_n = p;
        raw = r;
        repeat (4) @(posedge clk);
    endtask
    task automatic pst(input logic p, input logic [3:0] tx, input logic [3:0] rx);
        @(negedge clk);
        chk("powered", {7'h00, pwr}, {7'h00, p});
        chk("tx", {4'h0, tx_en}, {4'h0, tx});
        chk("rx", {ld_en, rx_en}, {rx, rx});
    endtask
    task automatic t_reset();
        pst(1'b1, 4'hF, 4'h1);
        rd(`XPS_OFS_CTRL);
        chk("ctrl_rst", q, 8'h0F);
        rd(`XPS_OFS_PRESENCE);
        chk("pres_rst", q, 8'h00);
    endtask
    task automatic t_route();
        wr(`XPS_OFS_ROUTE, 8'hE4);
        pst(1'b1, 4'hF, 4'hF);
        wr(`XPS_OFS_CTRL, 8'h06);
        pst(1'b1, 4'h6, 4'h6);
        wr(`XPS_OFS_ROUTE, 8'h2D);
        pst(1'b1, 4'h6, 4'hC);
        rd(`XPS_OFS_ROUTE);
        chk("route", q, 8'h2D);
    endtask
    task automatic t_sleep();
        pins(1'b0, 4'hA);
        pst(1'b0, 4'h0, 4'h0);
        wr(`XPS_OFS_CTRL, 8'h46);
        pst(1'b0, 4'h0, 4'hF);
        rd(`XPS_OFS_PRESENCE);
        chk("pres", q, 8'h0A);
        wr(`XPS_OFS_PRESENCE, 8'hFF);
        rd(`XPS_OFS_PRESENCE);
        chk("pres_ro", q, 8'h0A);
        wr(`XPS_OFS_CTRL, 8'h86);
        pst(1'b1, 4'h6, 4'hC);
        wr(`XPS_OFS_CTRL, 8'hC0);
        pst(1'b1, 4'h0, 4'hF);
        rd(8'h07);
        chk("unmapped", q, 8'h00);
        pins(1'b1, 4'h5);
        wr(`XPS_OFS_CTRL, 8'h01);
        pst(1'b1, 4'h1, 4'h2);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Whole run is about 77 us; this only cuts a hang short
    initial begin
        #600000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_route();
        t_sleep();
        tally_and_finish();
    end
endmodule // xps_power_status_tb
`default_nettype wire

// ===== xps_smb_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "xps_map.vh"
// ==========================================
// Serial host; clock idles high between frames
module xps_smb_host (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start();
        #24 sda_drv = 1'b1;
        #40 scl = 1'b1;
        #80 sda_drv = 1'b0;
        #80 scl = 1'b0;
    endtask
    task automatic stop();
        #24 sda_drv = 1'b0;
        #40 scl = 1'b1;
        #80 sda_drv = 1'b1;
        #80;
    endtask
    // Nine bits MSB first; a 1 releases the line so the target may answer
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #24 sda_drv = tx[i];
            #56 scl = 1'b1;
            #40 rx[i] = sda_line;
            #40 scl = 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [2:0] nak);
        logic [8:0] r0, r1, r2;
        start();
        xfer({`XPS_SMB_ADDR, 1'b0, 1'b1}, r0);
        xfer({a, 1'b1}, r1);
        xfer({d, 1'b1}, r2);
        stop();
        nak = {r0[0], r1[0], r2[0]};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic [8:0] r;
        start();
        xfer({`XPS_SMB_ADDR, 1'b0, 1'b1}, r);
        xfer({a, 1'b1}, r);
        start();
        xfer({`XPS_SMB_ADDR, 1'b1, 1'b1}, r);
        xfer(9'h1FF, r);
        stop();
        q = r[8:1];
    endtask
endmodule // xps_smb_host
`default_nettype wire
